// file: spc_pkg.sv
package spc_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] SPC_CTRL_OFS = 8'h00;
    localparam logic [7:0] SPC_STAT_OFS = 8'h04;
    localparam logic [7:0] SPC_MASK_OFS = 8'h08;

    // field positions of serial_port_control_reg
    localparam int SPC_RX_FLAG_POS = 0;
    localparam int SPC_TX_FLAG_POS = 1;
    localparam int SPC_RX9_POS = 2;
    localparam int SPC_TX9_POS = 3;
    localparam int SPC_RX_EN_POS = 4;
    localparam int SPC_MP_POS = 5;
    localparam int SPC_MODE_LSB = 6;

    // field positions of the interrupt status and mask registers
    localparam int SPC_IRQ_RX_POS = 0;
    localparam int SPC_IRQ_TX_POS = 1;

    // reset values
    localparam logic [7:0] SPC_CTRL_RST = 8'h00;
    localparam logic [1:0] SPC_IRQ_RST = 2'h0;

    // serial modes
    typedef enum logic [1:0] {
        SPC_MODE_SHIFT = 2'h0,
        SPC_MODE_ASYNC8 = 2'h1,
        SPC_MODE_ASYNC9 = 2'h2,
        SPC_MODE_ASYNC9V = 2'h3
    } spc_mode_t;

    // control register layout, msb first
    typedef struct packed {
        spc_mode_t mode;
        logic mp;
        logic rx_en;
        logic tx9;
        logic rx9;
        logic tx_flag;
        logic rx_flag;
    } spc_ctrl_t;

    // events from the serial shift logic, each a one-cycle pulse except the rx_ninth data bit
    typedef struct packed {
        logic tx_bit8;
        logic tx_stop;
        logic rx_bit8;
        logic rx_frame;
        logic rx_ninth;
    } spc_evt_t;
endpackage

// file: spc_flags.sv
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
// Operation
// - receive only while receive enable set
// - nine-bit modes send the transmit ninth bit
// - nine-bit modes store received ninth bit
// - mode one without multiprocessor stores stop bit
// - shift mode sets transmit flag after bit eight
// - shift mode sets receive flag after bit eight
// - other modes set transmit flag at stop
module spc_flags
    import spc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    input wire spc_evt_t SHIFT_EVT,
    output spc_mode_t SER_MODE,
    output logic MP_BIT,
    output logic RX_ENABLE,
    output logic TX_NINTH
);

    spc_ctrl_t ctrl_q, ctrl_d;
    logic [1:0] stat_q, stat_d;
    logic [1:0] mask_q, mask_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic setup, access, wr_ctrl, wr_mask, rd_stat, unmapped;
    logic tx_set, rx_set, rx_take9;
    logic [ADDR_W-1:0] addr_ctrl, addr_stat, addr_mask;

    assign addr_ctrl = ADDR_W'(SPC_CTRL_OFS);
    assign addr_stat = ADDR_W'(SPC_STAT_OFS);
    assign addr_mask = ADDR_W'(SPC_MASK_OFS);

    // apb phase decode; slave always ready in the access phase
    assign setup = PSEL && !PENABLE;
    assign access = PSEL && PENABLE;
    assign PREADY = 1'b1;
    assign wr_ctrl = access && PWRITE && (PADDR == addr_ctrl);
    assign wr_mask = access && PWRITE && (PADDR == addr_mask);
    assign rd_stat = access && !PWRITE && (PADDR == addr_stat);

    // true when an address selects one of the registers
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return (a == ADDR_W'(SPC_CTRL_OFS)) || (a == ADDR_W'(SPC_STAT_OFS)) || (a == ADDR_W'(SPC_MASK_OFS));
    endfunction

    // address matches none of the three registers
    assign unmapped = !addr_hit(PADDR);

    // flag events qualified by mode and receive enable
    always_comb begin
        if (ctrl_q.mode == SPC_MODE_SHIFT) begin
            tx_set = SHIFT_EVT.tx_bit8;
            rx_set = SHIFT_EVT.rx_bit8 && ctrl_q.rx_en;
        end else begin
            tx_set = SHIFT_EVT.tx_stop;
            rx_set = SHIFT_EVT.rx_frame && ctrl_q.rx_en;
        end
        // ninth bit of accepted frame, or stop bit in mode one without multiprocessor
        unique case (ctrl_q.mode)
            SPC_MODE_SHIFT: rx_take9 = 1'b0;
            SPC_MODE_ASYNC8: rx_take9 = rx_set && !ctrl_q.mp;
            SPC_MODE_ASYNC9, SPC_MODE_ASYNC9V: rx_take9 = rx_set;
        endcase
    end

    // control register: software writes, hardware sets flags, set beats clear
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d = spc_ctrl_t'(PWDATA[7:0]);
        end
        if (rx_take9) begin
            ctrl_d.rx9 = SHIFT_EVT.rx_ninth;
        end
        if (tx_set) begin
            ctrl_d.tx_flag = 1'b1;
        end
        if (rx_set) begin
            ctrl_d.rx_flag = 1'b1;
        end
    end

    // interrupt status: sticky, cleared by a read of the bits it returned
    always_comb begin
        stat_d = stat_q;
        mask_d = mask_q;
        if (rd_stat) begin
            stat_d = stat_q & ~rdata_q[1:0];
        end
        if (tx_set) begin
            stat_d[SPC_IRQ_TX_POS] = 1'b1;
        end
        if (rx_set) begin
            stat_d[SPC_IRQ_RX_POS] = 1'b1;
        end
        if (wr_mask) begin
            mask_d = PWDATA[1:0];
        end
    end

    // read data and error captured in the setup cycle
    always_comb begin
        rdata_d = rdata_q;
        err_d = err_q;
        if (setup) begin
            rdata_d = 32'h0000_0000;
            err_d = 1'b0;
            if (PADDR == addr_ctrl) begin
                rdata_d[7:0] = ctrl_q;
            end else if (PADDR == addr_stat) begin
                rdata_d[1:0] = stat_q;
            end else if (PADDR == addr_mask) begin
                rdata_d[1:0] = mask_q;
            end else begin
                err_d = 1'b1; // unmapped address
            end
        end
    end

    // control register flops
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            ctrl_q <= spc_ctrl_t'(SPC_CTRL_RST);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // interrupt status and mask flops
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            stat_q <= SPC_IRQ_RST;
            mask_q <= SPC_IRQ_RST;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
        end
    end

    // bus read data and error flops
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // outputs from flops; PSLVERR gated by the access phase, IRQ the OR of masked status
    assign PRDATA = rdata_q;
    assign PSLVERR = err_q && access;
    assign IRQ = |(stat_q & mask_q);
    assign SER_MODE = ctrl_q.mode;
    assign MP_BIT = ctrl_q.mp;
    assign RX_ENABLE = ctrl_q.rx_en;
    assign TX_NINTH = ctrl_q.tx9;

    // checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    sequence s_ctrl_write;
        PSEL && !PENABLE && PWRITE && (PADDR == addr_ctrl) ##1 PSEL && PENABLE;
    endsequence

    property p_rx_gate;
        (!ctrl_q.rx_en && !ctrl_q.rx_flag && !wr_ctrl) |=> !ctrl_q.rx_flag;
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("receive flag set while disabled");

    property p_tx_ninth;
        s_ctrl_write |=> (TX_NINTH == $past(PWDATA[SPC_TX9_POS]));
    endproperty
    a_tx_ninth: assert property (p_tx_ninth) else $error("transmit ninth bit not taken");

    property p_rx9_nine;
        (ctrl_q.mode[1] && ctrl_q.rx_en && SHIFT_EVT.rx_frame)
            |=> (ctrl_q.rx9 == $past(SHIFT_EVT.rx_ninth)) && ctrl_q.rx_flag;
    endproperty
    a_rx9_nine: assert property (p_rx9_nine) else $error("ninth bit not stored");

    property p_rx9_stop;
        (ctrl_q.mode == SPC_MODE_ASYNC8 && !ctrl_q.mp && ctrl_q.rx_en && SHIFT_EVT.rx_frame)
            |=> (ctrl_q.rx9 == $past(SHIFT_EVT.rx_ninth));
    endproperty
    a_rx9_stop: assert property (p_rx9_stop) else $error("stop bit not stored");

    property p_rx9_shift;
        (ctrl_q.mode == SPC_MODE_SHIFT && !wr_ctrl) |=> $stable(ctrl_q.rx9);
    endproperty
    a_rx9_shift: assert property (p_rx9_shift) else $error("ninth bit changed in shift mode");

    property p_tx_shift;
        (ctrl_q.mode == SPC_MODE_SHIFT && SHIFT_EVT.tx_bit8) |=> ctrl_q.tx_flag && stat_q[SPC_IRQ_TX_POS];
    endproperty
    a_tx_shift: assert property (p_tx_shift) else $error("transmit flag missed in shift mode");

    property p_rx_shift;
        (ctrl_q.mode == SPC_MODE_SHIFT && ctrl_q.rx_en && SHIFT_EVT.rx_bit8)
            |=> ctrl_q.rx_flag && stat_q[SPC_IRQ_RX_POS] && (IRQ || !mask_q[SPC_IRQ_RX_POS]);
    endproperty
    a_rx_shift: assert property (p_rx_shift) else $error("receive flag missed in shift mode");

    property p_tx_stop;
        (ctrl_q.mode != SPC_MODE_SHIFT && SHIFT_EVT.tx_stop) |=> ctrl_q.tx_flag;
    endproperty
    a_tx_stop: assert property (p_tx_stop) else $error("transmit flag missed at stop bit");

    property p_tx_hold;
        (ctrl_q.mode != SPC_MODE_SHIFT && !SHIFT_EVT.tx_stop && !ctrl_q.tx_flag && !wr_ctrl) |=> !ctrl_q.tx_flag;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("transmit flag set without stop bit");

    // bus, sticky flag, interrupt, hold and flag gating checks
    sequence s_ctrl_read;
        PSEL && !PENABLE && !PWRITE && (PADDR == addr_ctrl) ##1 PSEL && PENABLE;
    endsequence

    property p_ctrl_read;
        s_ctrl_read |-> (PRDATA == {24'h00_0000, $past(ctrl_q)});
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read data wrong");

    property p_slverr;
        access |-> (PSLVERR == unmapped);
    endproperty
    a_slverr: assert property (p_slverr) else $error("error response wrong");

    property p_err_ignore;
        (access && PWRITE && unmapped && !SHIFT_EVT.tx_bit8 && !SHIFT_EVT.tx_stop
            && !SHIFT_EVT.rx_bit8 && !SHIFT_EVT.rx_frame) |=> $stable(ctrl_q);
    endproperty
    a_err_ignore: assert property (p_err_ignore) else $error("unmapped write changed control");

    property p_stat_clear;
        (rd_stat && !tx_set && !rx_set) |=> ((stat_q & $past(rdata_q[1:0])) == 2'h0);
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status read did not clear");

    property p_mask_write;
        wr_mask |=> (mask_q == $past(PWDATA[1:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask write not taken");

    property p_irq_tx;
        (stat_q[SPC_IRQ_TX_POS] && mask_q[SPC_IRQ_TX_POS]) |-> IRQ;
    endproperty
    a_irq_tx: assert property (p_irq_tx) else $error("transmit interrupt missing");

    property p_irq_rx;
        (stat_q[SPC_IRQ_RX_POS] && mask_q[SPC_IRQ_RX_POS]) |-> IRQ;
    endproperty
    a_irq_rx: assert property (p_irq_rx) else $error("receive interrupt missing");

    property p_irq_off;
        ((stat_q & mask_q) == 2'h0) |-> !IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("interrupt without masked status");

    property p_tx_sticky;
        (ctrl_q.tx_flag && !wr_ctrl) |=> ctrl_q.tx_flag;
    endproperty
    a_tx_sticky: assert property (p_tx_sticky) else $error("transmit flag cleared by hardware");

    property p_rx_sticky;
        (ctrl_q.rx_flag && !wr_ctrl) |=> ctrl_q.rx_flag;
    endproperty
    a_rx_sticky: assert property (p_rx_sticky) else $error("receive flag cleared by hardware");

    property p_rx9_mp;
        (ctrl_q.mode == SPC_MODE_ASYNC8 && ctrl_q.mp && !wr_ctrl) |=> $stable(ctrl_q.rx9);
    endproperty
    a_rx9_mp: assert property (p_rx9_mp) else $error("ninth bit changed with multiprocessor set");

    property p_cfg_hold;
        !wr_ctrl |=> $stable({TX_NINTH, RX_ENABLE, MP_BIT, SER_MODE});
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("configuration changed without write");

    property p_rx_shift_only;
        (ctrl_q.mode == SPC_MODE_SHIFT && !SHIFT_EVT.rx_bit8 && !ctrl_q.rx_flag && !wr_ctrl) |=> !ctrl_q.rx_flag;
    endproperty
    a_rx_shift_only: assert property (p_rx_shift_only) else $error("receive flag set without bit eight");

    property p_rx_frame_only;
        (ctrl_q.mode != SPC_MODE_SHIFT && !SHIFT_EVT.rx_frame && !ctrl_q.rx_flag && !wr_ctrl) |=> !ctrl_q.rx_flag;
    endproperty
    a_rx_frame_only: assert property (p_rx_frame_only) else $error("receive flag set without frame");

endmodule

// file: spc_far_end.sv
`timescale 1ns/1ps
// far-side shift logic: turns one request into one event pulse
module spc_far_end
    import spc_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic SRST,
    input wire logic GO,
    input wire logic [1:0] SEL,
    input wire logic NINTH,
    output spc_evt_t SHIFT_EVT
);
    spc_evt_t evt_d;
    logic last_q;
    // one pulse per request; the ninth line shows junk outside a frame
    always_comb begin
        evt_d = '0;
        evt_d.tx_bit8 = GO && SEL == 2'h0;
        evt_d.tx_stop = GO && SEL == 2'h1;
        evt_d.rx_bit8 = GO && SEL == 2'h2;
        evt_d.rx_frame = GO && SEL == 2'h3;
        evt_d.rx_ninth = (GO && SEL == 2'h3) ? NINTH : ~last_q;
    end
    // register the pulse
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            SHIFT_EVT <= '0;
            last_q <= 1'b0;
        end else begin
            SHIFT_EVT <= evt_d;
            last_q <= evt_d.rx_ninth;
        end
    end
endmodule

// file: serial_port_control_flags_tb_top.sv
`timescale 1ns/1ps
// self-checking bench with an integer model of the flags
module serial_port_control_flags_tb_top
    import spc_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, ninth = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [1:0] sel = 2'h0;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, w;
    logic pready, pslverr, irq, mp_bit, rx_enable, tx_ninth, er;
    spc_evt_t shift_evt;
    spc_mode_t ser_mode;
    int fail_count = 0, total_checks = 0, cyc = 0, ctrl_m, stat_m, mask_m;
    logic [7:0] i_offs [3] = '{SPC_CTRL_OFS, SPC_STAT_OFS, SPC_MASK_OFS};
    spc_flags i_dut (.SYS_CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
        .SHIFT_EVT(shift_evt), .SER_MODE(ser_mode), .MP_BIT(mp_bit), .RX_ENABLE(rx_enable),
        .TX_NINTH(tx_ninth));
    spc_far_end i_far (.SYS_CLK(clk), .SRST(srst), .GO(go), .SEL(sel), .NINTH(ninth), .SHIFT_EVT(shift_evt));
    // clock and hang guard
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_sim();
        end
    end
    // compare one value
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // one apb transfer, entered just after a rising edge
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // one shift event from the far side, then update the model
    task evt(input logic [1:0] k, input logic b);
        int md, en, mp;
        go <= 1'b1;
        sel <= k;
        ninth <= b;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        md = (ctrl_m >> 6) & 3;
        en = (ctrl_m >> 4) & 1;
        mp = (ctrl_m >> 5) & 1;
        if ((k == 0 && md == 0) || (k == 1 && md != 0)) begin
            ctrl_m |= 2;
            stat_m |= 2;
        end
        if (en == 1 && ((k == 2 && md == 0) || (k == 3 && md != 0))) begin
            ctrl_m |= 1;
            stat_m |= 1;
            if (k == 3 && (md >= 2 || mp == 0)) ctrl_m = (ctrl_m & ~4) | (int'(b) << 2);
        end
    endtask
    // main sequence
    initial begin
        void'($urandom(32'h4af1_fa4b));
        ctrl_m = 0;
        stat_m = 0;
        mask_m = 0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk(32'(irq), 32'h0000_0000);
        foreach (i_offs[j]) begin
            apb(1'b0, i_offs[j], 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            chk(32'(er), 32'h0000_0000);
        end
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk({rd[31:1], er}, 32'h0000_0001);
        apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
        chk(32'(er), 32'h0000_0001);
        apb(1'b0, SPC_CTRL_OFS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        for (int i = 0; i < 80; i++) begin
            w = $urandom;
            apb(1'b1, SPC_CTRL_OFS, w);
            ctrl_m = int'(w[7:0]);
            mask_m = $urandom & 3;
            apb(1'b1, SPC_MASK_OFS, 32'(mask_m));
            chk(32'({ser_mode, mp_bit, rx_enable, tx_ninth}), 32'((ctrl_m >> 3) & 31));
            evt(2'($urandom), 1'($urandom));
            chk(32'(irq), 32'((stat_m & mask_m) != 0));
            apb(1'b0, SPC_CTRL_OFS, 32'h0000_0000);
            chk(rd, 32'(ctrl_m));
            apb(1'b0, SPC_STAT_OFS, 32'h0000_0000);
            chk(rd, 32'(stat_m));
            stat_m = 0;
            chk(32'(irq), 32'h0000_0000);
            apb(1'b0, SPC_MASK_OFS, 32'h0000_0000);
            chk(rd, 32'(mask_m));
        end
        end_sim();
    end
endmodule
